// *** include/hsg_pkg.sv ***
/*
  Shared constants and types of the two-wire bus slave with high-speed mode
  and General Call handling.
  Assumes a 100 MHz core clock; the bus clock arrives from the master.
*/
package hsg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPIKE_NS      = 10;
  // Least time, rounded up to whole cycles
  localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Frame layout and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] SLOT_SEEN     = 4'h1;
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [3:0] CNT_STEP      = 4'h1;
  localparam logic [7:0] HS_CODE_MASK  = 8'hF8;
  localparam logic [7:0] HS_CODE_VAL   = 8'h08;
  localparam logic [6:0] GC_ADDR       = 7'h00;
  localparam logic [7:0] GC_FORBIDDEN  = 8'h00;
  localparam logic [7:0] GC_RESET_CODE = 8'h06;
  localparam logic [7:0] GC_WAKE_CODE  = 8'h04;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic       LINE_IDLE     = 1'b1;
  localparam logic       PIN_LOW       = 1'b0;

  // ----------------------------------------------------------------
  // Slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_ACK    = 3'b010,
    ST_TX     = 3'b011,
    ST_TXACK  = 3'b100,
    ST_WAITSR = 3'b101,
    ST_IGNORE = 3'b110
  } hsg_state_t;

endpackage : hsg_pkg

// *** design/hsg_sync.sv ***
/*
  Three-stage pin synchroniser; the output follows once stages two and three agree.
  Assumes the input is asynchronous to clk and idles at RESET_VAL.
*/
`timescale 1ns/100ps
module hsg_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and result
  input  wire logic din,
  output logic      dout
);
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
      stage3_r <= RESET_VAL;
      dout     <= RESET_VAL;
    end
    else
    begin
      stage1_r <= din;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r)
      begin
        dout <= stage3_r;
      end
    end
  end
endmodule : hsg_sync

// *** design/hsg_spike_filter.sv ***
/*
  Spike filter: while enabled, a new level is taken only after it has stood
  for more than HOLD_CYC cycles; while disabled the input passes with one cycle delay.
  Assumes a synchronised input on clk.
*/
`timescale 1ns/100ps
module hsg_spike_filter #(
  parameter int   HOLD_CYC  = 1,
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control and data
  input  wire logic enable,
  input  wire logic din,
  output logic      dout
);
  localparam int CW = $clog2(HOLD_CYC + 1);

  logic [CW-1:0] cnt_r;

  if (HOLD_CYC < 1 || HOLD_CYC > 255)
  begin : g_check
    $error("hsg_spike_filter: HOLD_CYC must lie in 1..255");
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      dout  <= RESET_VAL;
    end
    else if (din == dout)
    begin
      cnt_r <= '0;
    end
    else if (!enable || cnt_r == CW'(HOLD_CYC))
    begin
      cnt_r <= '0;
      dout  <= din;
    end
    else
    begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  spike_reject_a: assert property (@(posedge clk) disable iff (rst)
    ($changed(dout) && $past(enable) && $past(enable, 2)) |-> ($past(din) == dout && $past(din, 2) == dout))
    else $error("level taken after too short a pulse");

endmodule : hsg_spike_filter

// *** design/hsg_slave.sv ***
/*
  Two-wire bus slave: Start/Stop detection, address byte, high-speed entry
  and exit, General Call, clock stretching, repeated-start collision check.
  Assumes open-drain pads outside (output enable high pulls the line low),
  the bus clock also fed to linkClk, and ownAddr steady during a frame.
*/
`timescale 1ns/100ps
// How it works
// - In the restart window, a clock rise is noted whatever the data level; it is not itself a collision.
// - In the restart window, clock falling with no Start is a bus collision.
// - Data rising while clock high is a Stop; the transfer ends.
// - A Stop returns state_r, both line enables, hsMode and General Call tracking to idle.
// - A byte breaking the command format ends the frame with no effect.
// - Start or Stop inside a byte aborts the frame and flags it.
// - The first byte after a Start is the address byte.
// - Address byte: seven address bits, then the read/write bit.
// - Code 00001xxx after Start enters high-speed mode and gets no acknowledge.
// - In high-speed mode the slave runs both lines at up to 3.4 Mbit/s.
// - After high-speed entry, address byte then acknowledged data bytes follow.
// - Repeated Start keeps high-speed mode; Stop leaves it.
// - The first Stop after high-speed entry reverts to normal speed.
// - In high-speed mode clock pulses under 10 ns are rejected.
// - General Call bytes 04h, 06h and odd bytes are decoded separately.
// - Only one General Call command per General Call address; others refused.
// - The slave may hold the clock low after a received byte.
// - Data falling while clock high is a Start; a transfer begins.
// - Data bits are taken on each rising clock edge.
module hsg_slave
  import hsg_pkg::*;
#(
  parameter int SPIKE_HOLD = SPIKE_CYC
) (
  // Core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Link clock (bus clock line used as a clock)
  input  wire logic       linkClk,
  // Bus lines
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Device side
  input  wire logic [6:0] ownAddr,
  input  wire logic       rxHold,
  input  wire logic [7:0] txByte,
  output logic [7:0]      rxByte,
  output logic            rxValid,
  output logic            txTaken,
  output logic            addrRead,
  output logic            gcCmdValid,
  output logic            gcReset,
  output logic            gcWake,
  output logic            gcHardware,
  // Frame status
  output logic            hsMode,
  output logic            frameStart,
  output logic            frameStop,
  output logic            frameAbort,
  output logic            busCollision
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic       sclSync;
  logic       sdaSync;
  logic       sclF;
  logic       sdaF;
  logic       sclP_r;
  logic       sdaP_r;
  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic [7:0] linkShift_r;
  hsg_state_t state_r;
  logic [3:0] bitCnt_r;
  logic       firstByte_r;
  logic       readDir_r;
  logic       gcMode_r;
  logic       gcDone_r;
  logic       ackDo_r;
  logic       masterAck_r;
  logic [7:0] txShift_r;
  logic       byteDone;
  logic       isHsCode;
  logic       addrHit;
  logic       gcHit;
  logic       ackNxt;
  logic       midByte;

  assign sclOut = PIN_LOW;
  assign sdaOut = PIN_LOW;

  // ----------------------------------------------------------------
  // Link domain: bit capture on the bus clock
  // ----------------------------------------------------------------
  // The word is read by the core only while the clock is low after the
  // eighth rise, when it cannot change
  always_ff @(posedge linkClk or posedge rst)
  begin
    if (rst)
    begin
      linkShift_r <= BYTE_ZERO;
    end
    else
    begin
      linkShift_r <= {linkShift_r[6:0], sdaIn};
    end
  end

  // ----------------------------------------------------------------
  // Line conditioning and bus conditions
  // ----------------------------------------------------------------
  hsg_sync #(.RESET_VAL(LINE_IDLE)) u_sync_scl (
    .clk  (core_clk),
    .rst  (rst),
    .din  (sclIn),
    .dout (sclSync)
  );

  hsg_sync #(.RESET_VAL(LINE_IDLE)) u_sync_sda (
    .clk  (core_clk),
    .rst  (rst),
    .din  (sdaIn),
    .dout (sdaSync)
  );

  // Both lines filtered alike so Start/Stop keep their timing
  hsg_spike_filter #(.HOLD_CYC(SPIKE_HOLD), .RESET_VAL(LINE_IDLE)) u_filt_scl (
    .clk    (core_clk),
    .rst    (rst),
    .enable (hsMode),
    .din    (sclSync),
    .dout   (sclF)
  );

  hsg_spike_filter #(.HOLD_CYC(SPIKE_HOLD), .RESET_VAL(LINE_IDLE)) u_filt_sda (
    .clk    (core_clk),
    .rst    (rst),
    .enable (hsMode),
    .din    (sdaSync),
    .dout   (sdaF)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sclP_r <= LINE_IDLE;
      sdaP_r <= LINE_IDLE;
    end
    else
    begin
      sclP_r <= sclF;
      sdaP_r <= sdaF;
    end
  end

  assign sclRise  = sclF & ~sclP_r;
  assign sclFall  = ~sclF & sclP_r;
  assign startDet = sclF & sclP_r & sdaP_r & ~sdaF;
  assign stopDet  = sclF & sclP_r & ~sdaP_r & sdaF;
  // A condition after one rise sits where a Stop or repeated Start belongs
  assign midByte  = (state_r == ST_RX || state_r == ST_TX) && bitCnt_r > SLOT_SEEN;
  assign byteDone = (state_r == ST_RX) && sclFall && bitCnt_r == BYTE_BITS;

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------
  always_comb
  begin
    isHsCode = (linkShift_r & HS_CODE_MASK) == HS_CODE_VAL;
    addrHit  = linkShift_r[7:1] == ownAddr;
    gcHit    = linkShift_r[7:1] == GC_ADDR && !linkShift_r[0];
    if (firstByte_r)
    begin
      ackNxt = !isHsCode && (addrHit || gcHit);
    end
    else if (gcMode_r)
    begin
      ackNxt = !gcDone_r && linkShift_r != GC_FORBIDDEN;
    end
    else
    begin
      ackNxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      bitCnt_r    <= CNT_ZERO;
      firstByte_r <= 1'b0;
      readDir_r   <= 1'b0;
      ackDo_r     <= 1'b0;
      masterAck_r <= 1'b0;
    end
    else if (stopDet)
    begin
      state_r     <= ST_IDLE;
      bitCnt_r    <= CNT_ZERO;
      firstByte_r <= 1'b0;
      readDir_r   <= 1'b0;
      ackDo_r     <= 1'b0;
    end
    else if (startDet)
    begin
      state_r     <= ST_RX;
      bitCnt_r    <= CNT_ZERO;
      firstByte_r <= 1'b1;
      readDir_r   <= 1'b0;
      ackDo_r     <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE, ST_IGNORE:
        begin
          bitCnt_r <= CNT_ZERO;
        end
        ST_RX:
        begin
          if (sclRise)
          begin
            bitCnt_r <= bitCnt_r + CNT_STEP;
          end
          else if (byteDone)
          begin
            state_r  <= ST_ACK;
            bitCnt_r <= CNT_ZERO;
            ackDo_r  <= ackNxt;
            if (firstByte_r)
            begin
              readDir_r <= linkShift_r[0];
            end
          end
        end
        ST_ACK:
        begin
          if (sclRise)
          begin
            bitCnt_r <= SLOT_SEEN;
          end
          else if (sclFall && bitCnt_r == SLOT_SEEN)
          begin
            bitCnt_r    <= CNT_ZERO;
            firstByte_r <= 1'b0;
            if (!ackDo_r)
            begin
              state_r <= ST_IGNORE;
            end
            else if (readDir_r)
            begin
              state_r <= ST_TX;
            end
            else
            begin
              state_r <= ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (sclRise)
          begin
            bitCnt_r <= bitCnt_r + CNT_STEP;
          end
          else if (sclFall && bitCnt_r == BYTE_BITS)
          begin
            state_r  <= ST_TXACK;
            bitCnt_r <= CNT_ZERO;
          end
        end
        ST_TXACK:
        begin
          if (sclRise)
          begin
            bitCnt_r    <= SLOT_SEEN;
            masterAck_r <= ~sdaF;
          end
          else if (sclFall && bitCnt_r == SLOT_SEEN)
          begin
            bitCnt_r <= CNT_ZERO;
            state_r  <= masterAck_r ? ST_TX : ST_WAITSR;
          end
        end
        ST_WAITSR:
        begin
          if (sclRise)
          begin
            bitCnt_r <= SLOT_SEEN;
          end
          else if (sclFall && bitCnt_r == SLOT_SEEN)
          begin
            state_r <= ST_IGNORE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line drive: acknowledge, read data, clock hold
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sdaOe     <= 1'b0;
      sclOe     <= 1'b0;
      txShift_r <= BYTE_ZERO;
    end
    else if (startDet || stopDet)
    begin
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end
    else
    begin
      // Pull only from the slot's first cycle; re-pulling after a release would clip a clock pulse
      sclOe <= byteDone ? rxHold : (sclOe && rxHold && (state_r == ST_ACK) && bitCnt_r == CNT_ZERO);
      if (byteDone)
      begin
        sdaOe <= ackNxt;
      end
      else if (state_r == ST_ACK && sclFall && bitCnt_r == SLOT_SEEN)
      begin
        txShift_r <= txByte;
        sdaOe     <= ackDo_r && readDir_r && !txByte[7];
      end
      else if (state_r == ST_TXACK && sclFall && bitCnt_r == SLOT_SEEN)
      begin
        txShift_r <= txByte;
        sdaOe     <= masterAck_r && !txByte[7];
      end
      else if (state_r == ST_TX && sclFall)
      begin
        txShift_r <= {txShift_r[6:0], 1'b0};
        sdaOe     <= (bitCnt_r != BYTE_BITS) && !txShift_r[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // Speed mode
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hsMode <= 1'b0;
    end
    else if (stopDet)
    begin
      hsMode <= 1'b0;
    end
    else if (byteDone && firstByte_r && isHsCode)
    begin
      hsMode <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // General Call tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      gcMode_r <= 1'b0;
      gcDone_r <= 1'b0;
    end
    else if (startDet || stopDet)
    begin
      gcMode_r <= 1'b0;
      gcDone_r <= 1'b0;
    end
    else if (byteDone && firstByte_r)
    begin
      gcMode_r <= gcHit && !isHsCode;
    end
    else if (byteDone && gcMode_r)
    begin
      gcDone_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Device-side pulses
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rxByte       <= BYTE_ZERO;
      rxValid      <= 1'b0;
      txTaken      <= 1'b0;
      addrRead     <= 1'b0;
      gcCmdValid   <= 1'b0;
      gcReset      <= 1'b0;
      gcWake       <= 1'b0;
      gcHardware   <= 1'b0;
      frameStart   <= 1'b0;
      frameStop    <= 1'b0;
      frameAbort   <= 1'b0;
      busCollision <= 1'b0;
    end
    else
    begin
      rxValid      <= byteDone && !firstByte_r && !gcMode_r;
      gcCmdValid   <= byteDone && !firstByte_r && gcMode_r && ackNxt;
      gcReset      <= byteDone && !firstByte_r && gcMode_r && ackNxt && linkShift_r == GC_RESET_CODE;
      gcWake       <= byteDone && !firstByte_r && gcMode_r && ackNxt && linkShift_r == GC_WAKE_CODE;
      gcHardware   <= byteDone && !firstByte_r && gcMode_r && ackNxt && linkShift_r[0];
      txTaken      <= sclFall && bitCnt_r == SLOT_SEEN && ((state_r == ST_ACK && ackDo_r && readDir_r)
                      || (state_r == ST_TXACK && masterAck_r));
      frameStart   <= startDet;
      frameStop    <= stopDet;
      frameAbort   <= (startDet || stopDet) && midByte;
      busCollision <= !stopDet && !startDet && state_r == ST_WAITSR && sclFall && bitCnt_r == SLOT_SEEN;
      if (byteDone)
      begin
        rxByte <= linkShift_r;
      end
      if (byteDone && firstByte_r && ackNxt)
      begin
        addrRead <= linkShift_r[0];
      end
      else if (startDet || stopDet)
      begin
        addrRead <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  stop_idle_a: assert property (stopDet |=> (state_r == ST_IDLE && !sdaOe && !gcMode_r))
    else $error("stop did not return the slave to idle");

  hs_exit_a: assert property (stopDet |=> !hsMode)
    else $error("high-speed mode survived a stop");

  start_addr_a: assert property (startDet |=> (state_r == ST_RX && firstByte_r && bitCnt_r == CNT_ZERO))
    else $error("start did not arm the address byte");

  hs_entry_a: assert property ((byteDone && firstByte_r && isHsCode) |=> (hsMode && !sdaOe && !ackDo_r))
    else $error("high-speed code mishandled");

  hs_keep_a: assert property ((hsMode && startDet) |=> hsMode)
    else $error("repeated start dropped high-speed mode");

  gc_once_a: assert property ((byteDone && gcMode_r && gcDone_r) |=> (!sdaOe && !gcCmdValid))
    else $error("second general call command accepted");

  foreign_ignore_a: assert property ((byteDone && firstByte_r && !addrHit && !gcHit)
    |=> !sdaOe ##1 (!sdaOe)[*3])
    else $error("foreign address drew an acknowledge");

  abort_flag_a: assert property (((startDet || stopDet) && midByte) |=> frameAbort)
    else $error("mid-byte condition did not abort the frame");

  collision_a: assert property ((state_r == ST_WAITSR && sclFall && bitCnt_r == SLOT_SEEN)
    |=> (busCollision && state_r == ST_IGNORE))
    else $error("restart collision missed");

  stretch_once_a: assert property ($rose(sclOe) |-> $past(byteDone))
    else $error("clock hold started outside the acknowledge slot");

endmodule : hsg_slave

// *** dv/hsg_master_model.sv ***
/*
  Behavioural two-wire bus master that pulls the lines through enables.
  Assumes pull-ups outside: a released line reads high.
*/
`timescale 1ns/100ps
module hsg_master_model (
  // Resolved lines
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Pull-down enables and hang flag
  output logic      sclPull,
  output logic      sdaPull,
  output logic      stuck
);
  // ----------------------------------------------------------------
  // Bit-level sequences on a 24 ns tick
  // ----------------------------------------------------------------
  int nStarts = 0;
  int nStops  = 0;

  initial
  begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    stuck   = 1'b0;
  end

  // Release the clock; a stretching slave may keep it low for a while
  task automatic rise;
    int n;
    n = 0;
    sclPull = 1'b0;
    #4;
    while (!sclLine && n < 400)
    begin
      #24;
      n++;
    end
    if (!sclLine)
      stuck = 1'b1;
    #24;
  endtask : rise

  // Data set while the clock is low, sampled mid-high
  task automatic bit_cyc(input logic b, output logic s);
    #24;
    sdaPull = !b;
    #96;
    rise();
    s = sdaLine;
    #48;
    sclPull = 1'b1;
  endtask : bit_cyc

  task automatic start_cond;
    #24;
    sdaPull = 1'b0;
    #72;
    rise();
    #48;
    sdaPull = 1'b1;
    nStarts++;
    #72;
    sclPull = 1'b1;
  endtask : start_cond

  task automatic stop_cond;
    #24;
    sdaPull = 1'b1;
    #96;
    rise();
    #48;
    sdaPull = 1'b0;
    nStops++;
    #96;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] v, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(v[i], s);
    bit_cyc(1'b1, s);
    acked = !s;
  endtask : send_byte

  task automatic recv_byte(input logic ackIt, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b1, s);
      v[i] = s;
    end
    bit_cyc(!ackIt, s);
  endtask : recv_byte
endmodule : hsg_master_model

// *** dv/tb_hsg_slave.sv ***
/*
  Self-checking bench of the bus slave against an event queue model.
  Assumes the master model file and the design package are compiled first.
*/
`timescale 1ns/100ps
module tb_hsg_slave;
  import hsg_pkg::*;
  logic core_clk, rst, mScl, mSda, stuck, sclLine, sdaLine, sclOut, sclOe, sdaOut, sdaOe;
  logic rxHold, holdEn, rxValid, txTaken, addrRead, gcCmdValid, gcReset, gcWake, gcHardware;
  logic hsMode, frameStart, frameStop, frameAbort, busCollision, a, s;
  logic [6:0]  ownAddr;
  logic [7:0]  txByte, rxByte, d, v, t2;
  logic [31:0] seed = 32'h00000058;
  logic [11:0] evQ[$];
  logic [11:0] expQ[$];
  int          mismatches = 0;
  int          num_checks = 0;
  int          startSeen = 0;
  int          stopSeen = 0;
  int          takenSeen = 0;
  logic [7:0]  gcCodes[2];

  // ----------------------------------------------------------------
  // Clock, lines, design and master
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #5 core_clk = !core_clk;
  assign sclLine = !(mScl | sclOe);
  assign sdaLine = !(mSda | sdaOe);

  hsg_slave dut_u (.core_clk(core_clk), .rst(rst), .linkClk(sclLine), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .ownAddr(ownAddr), .rxHold(rxHold),
    .txByte(txByte), .rxByte(rxByte), .rxValid(rxValid), .txTaken(txTaken), .addrRead(addrRead),
    .gcCmdValid(gcCmdValid), .gcReset(gcReset), .gcWake(gcWake), .gcHardware(gcHardware), .hsMode(hsMode),
    .frameStart(frameStart), .frameStop(frameStop), .frameAbort(frameAbort), .busCollision(busCollision));
  hsg_master_model m_u (.sclLine(sclLine), .sdaLine(sdaLine), .sclPull(mScl), .sdaPull(mSda), .stuck(stuck));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_of_test;
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic drain;
    repeat (20) @(negedge core_clk);
    check(12'(evQ.size()), 12'(expQ.size()));
    check(12'(startSeen), 12'(m_u.nStarts));
    check(12'(stopSeen), 12'(m_u.nStops));
    check({sclOut, sdaOut}, 12'h0);
    while (evQ.size() > 0 && expQ.size() > 0)
      check(evQ.pop_front(), expQ.pop_front());
    evQ.delete();
    expQ.delete();
  endtask : drain

  always @(posedge core_clk)
  begin
    if (rxValid === 1'b1)
      evQ.push_back({4'h1, rxByte});
    if (gcCmdValid === 1'b1)
      evQ.push_back({1'b1, gcReset, gcWake, gcHardware, rxByte});
    if (frameAbort === 1'b1)
      evQ.push_back(12'h300);
    if (busCollision === 1'b1)
      evQ.push_back(12'h400);
    if (frameStart === 1'b1)
      startSeen++;
    if (frameStop === 1'b1)
      stopSeen++;
    if (txTaken === 1'b1)
      takenSeen++;
  end

  always @(negedge core_clk)
  begin
    rxHold <= holdEn & seed[9];
    void'(rnd());
  end

  always @(posedge stuck)
  begin
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    holdEn = 1'b0;
    rxHold = 1'b0;
    txByte = 8'h00;
    ownAddr = 7'(rnd()) | 7'h40;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    holdEn = 1'b1;
    // Writes at normal speed, then after entering high speed
    for (int k = 0; k < 2; k++)
    begin
      m_u.start_cond();
      if (k == 1)
      begin
        m_u.send_byte(HS_CODE_VAL | 8'(rnd() & 32'h7), a);
        check(a, 12'h0);
        m_u.start_cond();
        check(hsMode, 12'h1);
      end
      m_u.send_byte({ownAddr, 1'b0}, a);
      check(a, 12'h1);
      repeat (2)
      begin
        d = 8'(rnd());
        m_u.send_byte(d, a);
        check(a, 12'h1);
        expQ.push_back({4'h1, d});
      end
      m_u.stop_cond();
      drain();
      check(hsMode, 12'h0);
    end
    // Foreign address: refused, and the rest of the frame is ignored
    m_u.start_cond();
    m_u.send_byte({ownAddr ^ 7'h01, 1'b0}, a);
    check(a, 12'h0);
    m_u.send_byte(8'(rnd()), a);
    check(a, 12'h0);
    m_u.stop_cond();
    drain();
    // Read two bytes, refuse the last, then a clock pulse with data low
    txByte = 8'(rnd());
    t2 = 8'(rnd());
    m_u.start_cond();
    m_u.send_byte({ownAddr, 1'b1}, a);
    check({a, addrRead}, 12'h3);
    repeat (10) @(negedge core_clk);
    d = txByte;
    txByte = t2;
    m_u.recv_byte(1'b1, v);
    check(v, d);
    m_u.recv_byte(1'b0, v);
    check(v, t2);
    m_u.bit_cyc(1'b0, s);
    expQ.push_back(12'h400);
    m_u.stop_cond();
    drain();
    check(12'(takenSeen), 12'h2);
    // Stop after three bits of a data byte
    m_u.start_cond();
    m_u.send_byte({ownAddr, 1'b0}, a);
    repeat (3)
      m_u.bit_cyc(seed[4], s);
    m_u.stop_cond();
    expQ.push_back(12'h300);
    drain();
    // General Call: one command accepted, a second refused; never a zero byte
    gcCodes[0] = GC_WAKE_CODE;
    gcCodes[1] = 8'(rnd()) | 8'h01;
    m_u.start_cond();
    m_u.send_byte({GC_ADDR, 1'b0}, a);
    m_u.send_byte(GC_RESET_CODE, a);
    check(a, 12'h1);
    expQ.push_back({4'hC, GC_RESET_CODE});
    m_u.send_byte(GC_WAKE_CODE, a);
    check(a, 12'h0);
    m_u.stop_cond();
    drain();
    foreach (gcCodes[i])
    begin
      d = gcCodes[i];
      m_u.start_cond();
      m_u.send_byte({GC_ADDR, 1'b0}, a);
      m_u.send_byte(d, a);
      m_u.stop_cond();
      expQ.push_back({1'b1, d == GC_RESET_CODE, d == GC_WAKE_CODE, d[0], d});
      drain();
    end
    end_of_test();
  end
endmodule : tb_hsg_slave
